//--- verilog/sprt_pkg.sv
package sprt_pkg;
    ////////////////////////////////////////////////////////////////
    ////////////////////////////////////////////////////////////////

    localparam int ADDR_W = 12;

    // Register indices, byte address is four times the index
    localparam logic [7:0] IDX_POWER_CONTROL   = 8'h87;
    localparam logic [7:0] IDX_TMR1_RELOAD_HI  = 8'h8d;
    localparam logic [7:0] IDX_SERIAL_CONTROL  = 8'h98;
    localparam logic [7:0] IDX_SERIAL_DATA     = 8'h99;
    localparam logic [7:0] IDX_TMR2_CONTROL    = 8'hc8;
    localparam logic [7:0] IDX_TMR2_RELOAD_LO  = 8'hca;
    localparam logic [7:0] IDX_TMR2_RELOAD_HI  = 8'hcb;

    // serial_control fields
    localparam int SC_MODE_HI  = 7;
    localparam int SC_MODE_LO  = 6;
    localparam int SC_MPF      = 5;
    localparam int SC_RX_EN    = 4;
    localparam int SC_TX_NINTH = 3;
    localparam int SC_RX_NINTH = 2;
    localparam int SC_TX_DONE  = 1;
    localparam int SC_RX_DONE  = 0;

    // power_control and timer2_control fields
    localparam int PC_BAUD_DBL   = 7;
    localparam int TMR2_OVF      = 7;
    localparam int TMR2_EXT_FLAG = 6;
    localparam int TMR2_RX_BAUD  = 5;
    localparam int TMR2_TX_BAUD  = 4;
    localparam int TMR2_EXT_EN   = 3;
    localparam int TMR2_RUN      = 2;
    localparam int TMR2_EXT_CLK  = 1;
    localparam int TMR2_CAPTURE  = 0;

    // Reset values
    localparam logic [7:0] RST_SERIAL_CONTROL = 8'h00;
    localparam logic [7:0] RST_POWER_CONTROL  = 8'h00;
    localparam logic [7:0] RST_TMR2_CONTROL   = 8'h00;
    localparam logic [7:0] RST_RELOAD         = 8'h00;

    // Timing counts in oscillator cycles or in oversampling ticks
    localparam int MODE0_DIV    = 12;
    localparam int PRESCALE_DIV = 12;
    localparam int OVERSAMPLE   = 16;
    localparam logic [3:0] PRE_RELOAD    = 4'(16 - PRESCALE_DIV);
    localparam logic [3:0] SUB_LAST_M0   = 4'(MODE0_DIV - 1);
    localparam logic [3:0] SUB_LAST_UART = 4'(OVERSAMPLE - 1);
    localparam logic [3:0] SUB_MID       = 4'(OVERSAMPLE / 2 - 1);
    localparam logic [3:0] M0_CLK_HIGH   = 4'(MODE0_DIV / 2);
    localparam logic [3:0] M0_SAMPLE     = 4'h9;

    // Bit indices within a frame
    localparam logic [3:0] M0_LAST      = 4'h7;
    localparam logic [3:0] TX_STOP_M8   = 4'h9;
    localparam logic [3:0] TX_STOP_M9   = 4'ha;
    localparam logic [3:0] RX_LAST_M8   = 4'h8;
    localparam logic [3:0] RX_LAST_M9   = 4'h9;

    typedef enum logic [1:0] {
        MODE_SHIFT,
        MODE_UART8,
        MODE_UART9_FIXED,
        MODE_UART9_VAR
    } sprt_mode_e;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_START,
        ST_DATA
    } sprt_st_e;

endpackage : sprt_pkg

//--- verilog/sprt_reload_cnt.sv
`timescale 1ns/1ps

module sprt_reload_cnt #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         resetn,
    // Control
    input  wire logic         inc,
    input  wire logic         load,
    input  wire logic [W-1:0] reload,
    // Status
    output logic      [W-1:0] cnt,
    output logic              ovf
);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic         ovf;
    } sprt_cnt_s;

    sprt_cnt_s r;
    sprt_cnt_s n;

    // Overflow comes out registered, in the same cycle as the reloaded count
    always_comb
    begin
        n = r;
        n.ovf = 1'b0;
        if (load)
        begin
            n.cnt = reload;
        end
        else if (inc)
        begin
            if (&r.cnt)
            begin
                n.cnt = reload;
                n.ovf = 1'b1;
            end
            else
            begin
                n.cnt = r.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
            r <= '0;
        else
            r <= n;
    end

    assign cnt = r.cnt;
    assign ovf = r.ovf;

endmodule : sprt_reload_cnt

//--- verilog/sprt_top.sv
`timescale 1ns/1ps

module sprt_top (
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        resetn,
    // APB slave
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [sprt_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                 pwdata,
    output logic                             pready,
    output logic      [31:0]                 prdata,
    output logic                             pslverr,
    // Serial line
    input  wire logic                        rxd_in,
    output logic                             rxd_out,
    output logic                             rxd_oe,
    output logic                             txd,
    // Timer 2 pins
    input  wire logic                        timer2_clock_pin,
    input  wire logic                        timer2_ext_trigger
);
    import sprt_pkg::*;

    typedef struct packed {
        logic [7:0]  serial_control;
        logic [7:0]  power_control;
        logic [7:0]  t1rh;
        logic [7:0]  t2c;
        logic [7:0]  rl;
        logic [7:0]  rh;
        logic [7:0]  rbuf;
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
        logic        txd;
        logic        rxd_out;
        logic        rxd_oe;
        sprt_st_e    tx_st;
        logic [3:0]  tx_bit;
        logic [3:0]  tx_sub;
        logic [9:0]  tx_sh;
        sprt_st_e    rx_st;
        logic [3:0]  rx_bit;
        logic [3:0]  rx_sub;
        logic [8:0]  rx_sh;
        logic        t1_half;
        logic [1:0]  m2div;
        logic [2:0]  rxd_s;
        logic [2:0]  eclk_s;
        logic [2:0]  trig_s;
    } sprt_state_s;

    sprt_state_s r;
    sprt_state_s n;

    ////////////////////////////////////////////////////////////////
    // Decode and bus
    sprt_mode_e  mode;
    logic        m0;
    logic        m9;
    logic        ren;
    logic [7:0]  idx;
    logic        hit;
    logic [7:0]  rd8;
    logic        setup;
    logic        wr;
    logic        wr_serial_control;
    logic        wr_t2c;
    logic        wr_sbuf;
    logic [7:0]  wd8;

    // Timers and rate ticks
    logic        pre_ovf;
    logic        tmr1_ovf;
    logic        tmr2_ovf;
    logic        tmr2_inc;
    logic        tmr2_ld;
    logic [15:0] tmr2_rl;
    logic [15:0] tmr2_cnt;
    logic        baud;
    logic        run;
    logic        extclk;
    logic        trig;
    logic        rxd_lvl;
    logic        rxd_fall;
    logic        t1_tick;
    logic        m2_tick;
    logic        tx_tick;
    logic        rx_tick;
    logic [3:0]  sub_last;
    logic [3:0]  tx_stop;
    logic [3:0]  rx_last;
    logic [8:0]  smp;
    logic        rx_done;
    logic        m2_fast;
    logic        m2_slow;

    assign mode     = sprt_mode_e'(r.serial_control[SC_MODE_HI:SC_MODE_LO]);
    assign m0       = (mode == MODE_SHIFT);
    assign m9       = r.serial_control[SC_MODE_HI];
    assign ren      = r.serial_control[SC_RX_EN];
    assign idx      = paddr[9:2];
    assign setup    = psel & ~penable;
    assign wd8      = pwdata[7:0];
    assign wr       = psel & penable & r.pready & pwrite & hit;
    assign wr_serial_control  = wr & (idx == IDX_SERIAL_CONTROL);
    assign wr_t2c   = wr & (idx == IDX_TMR2_CONTROL);
    assign wr_sbuf  = wr & (idx == IDX_SERIAL_DATA);

    always_comb
    begin
        hit = (paddr[ADDR_W-1:10] == 2'h0);
        case (idx)
            IDX_POWER_CONTROL:  rd8 = r.power_control;
            IDX_TMR1_RELOAD_HI: rd8 = r.t1rh;
            IDX_SERIAL_CONTROL: rd8 = r.serial_control;
            IDX_SERIAL_DATA:    rd8 = r.rbuf;
            IDX_TMR2_CONTROL:   rd8 = r.t2c;
            IDX_TMR2_RELOAD_LO: rd8 = r.rl;
            IDX_TMR2_RELOAD_HI: rd8 = r.rh;
            default:
            begin
                rd8 = 8'h00;
                hit = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////
    // Timers
    assign baud     = r.t2c[TMR2_RX_BAUD] | r.t2c[TMR2_TX_BAUD];
    assign run      = r.t2c[TMR2_RUN];
    assign extclk   = r.t2c[TMR2_EXT_CLK];
    assign rxd_lvl  = r.rxd_s[1];
    assign rxd_fall = r.rxd_s[2] & ~r.rxd_s[1];
    // Edge trigger is ignored while timer 2 makes baud rates
    assign trig     = r.trig_s[2] & ~r.trig_s[1] & r.t2c[TMR2_EXT_EN] & ~baud;
    assign tmr2_ld  = trig & ~r.t2c[TMR2_CAPTURE];
    assign tmr2_rl  = (r.t2c[TMR2_CAPTURE] & ~baud) ? 16'h0000 : {r.rh, r.rl};
    // Internal clock: baud mode counts at osc/2, otherwise at osc/12; external clock counts pin falls
    assign tmr2_inc = run & (extclk ? (r.eclk_s[2] & ~r.eclk_s[1])
                                    : (baud ? r.m2div[0] : pre_ovf));

    sprt_reload_cnt #(.W(4)) u_pre (
        .clk    (clk),
        .resetn (resetn),
        .inc    (1'b1),
        .load   (1'b0),
        .reload (PRE_RELOAD),
        .cnt    (),
        .ovf    (pre_ovf)
    );

    // Timer 1 in 8-bit auto-reload, ticking at osc/12
    sprt_reload_cnt #(.W(8)) u_tmr1 (
        .clk    (clk),
        .resetn (resetn),
        .inc    (pre_ovf),
        .load   (1'b0),
        .reload (r.t1rh),
        .cnt    (),
        .ovf    (tmr1_ovf)
    );

    sprt_reload_cnt #(.W(16)) u_tmr2 (
        .clk    (clk),
        .resetn (resetn),
        .inc    (tmr2_inc),
        .load   (tmr2_ld),
        .reload (tmr2_rl),
        .cnt    (tmr2_cnt),
        .ovf    (tmr2_ovf)
    );

    ////////////////////////////////////////////////////////////////
    // Oversampling ticks, sixteen per bit outside mode 0
    assign t1_tick  = tmr1_ovf & (r.power_control[PC_BAUD_DBL] | r.t1_half);
    assign m2_tick  = r.power_control[PC_BAUD_DBL] ? r.m2div[0] : (&r.m2div);
    // Modes 1 and 3 share one selection
    assign tx_tick  = m0 | ((mode == MODE_UART9_FIXED) ? m2_tick
                         : (r.t2c[TMR2_TX_BAUD] ? tmr2_ovf : t1_tick));
    assign rx_tick  = m0 | ((mode == MODE_UART9_FIXED) ? m2_tick
                         : (r.t2c[TMR2_RX_BAUD] ? tmr2_ovf : t1_tick));
    assign sub_last = m0 ? SUB_LAST_M0 : SUB_LAST_UART;
    assign tx_stop  = m9 ? TX_STOP_M9 : TX_STOP_M8;
    assign rx_last  = m0 ? M0_LAST : (m9 ? RX_LAST_M9 : RX_LAST_M8);
    assign smp      = {rxd_lvl, r.rx_sh[8:1]};
    assign rx_done  = rx_tick & (r.rx_sub == sub_last) & (r.rx_bit == rx_last);
    // Rate checks only look where mode and doubler stayed put
    assign m2_fast  = (mode == MODE_UART9_FIXED) & r.power_control[PC_BAUD_DBL];
    assign m2_slow  = (mode == MODE_UART9_FIXED) & ~r.power_control[PC_BAUD_DBL];

    ////////////////////////////////////////////////////////////////
    // Next state
    always_comb
    begin
        n = r;
        // First stage feeds only the second
        n.rxd_s  = {r.rxd_s[1:0], rxd_in};
        n.eclk_s = {r.eclk_s[1:0], timer2_clock_pin};
        n.trig_s = {r.trig_s[1:0], timer2_ext_trigger};
        n.m2div  = r.m2div + 2'h1;
        if (tmr1_ovf)
            n.t1_half = ~r.t1_half;

        // No wait state: data latched in setup, ready in the first access cycle
        n.pready  = setup;
        n.pslverr = setup & ~hit;
        if (setup)
            n.prdata = {24'h000000, rd8};

        if (wr)
        begin
            case (idx)
                IDX_POWER_CONTROL:  n.power_control = wd8;
                IDX_TMR1_RELOAD_HI: n.t1rh = wd8;
                IDX_SERIAL_CONTROL: n.serial_control = wd8;
                IDX_TMR2_CONTROL:   n.t2c  = wd8;
                IDX_TMR2_RELOAD_LO: n.rl   = wd8;
                IDX_TMR2_RELOAD_HI: n.rh   = wd8;
                default:            n.rbuf = r.rbuf;
            endcase
        end

        // Hardware sets come after writes so a set wins
        if (tmr2_ovf & ~baud)
            n.t2c[TMR2_OVF] = 1'b1;
        if (trig)
        begin
            n.t2c[TMR2_EXT_FLAG] = 1'b1;
            if (r.t2c[TMR2_CAPTURE])
                {n.rh, n.rl} = tmr2_cnt;
        end

        // Transmitter
        case (r.tx_st)
            ST_IDLE:
            begin
                if (wr_sbuf)
                begin
                    n.tx_st  = ST_DATA;
                    n.tx_bit = 4'h0;
                    n.tx_sub = 4'h0;
                    if (m0)
                        n.tx_sh = {2'h3, wd8};
                    else
                        n.tx_sh = {r.serial_control[SC_TX_NINTH] | ~m9, wd8, 1'b0};
                end
            end
            ST_DATA:
            begin
                if (tx_tick)
                begin
                    if (r.tx_sub == sub_last)
                    begin
                        n.tx_sub = 4'h0;
                        n.tx_bit = r.tx_bit + 4'h1;
                        n.tx_sh  = {1'b1, r.tx_sh[9:1]};
                        if (m0 && r.tx_bit == M0_LAST)
                        begin
                            n.tx_st = ST_IDLE;
                            n.serial_control[SC_TX_DONE] = 1'b1;
                        end
                        else if (!m0 && r.tx_bit == tx_stop)
                        begin
                            n.tx_st = ST_IDLE;
                        end
                        else if (!m0 && n.tx_bit == tx_stop)
                        begin
                            n.serial_control[SC_TX_DONE] = 1'b1;
                        end
                    end
                    else
                    begin
                        n.tx_sub = r.tx_sub + 4'h1;
                    end
                end
            end
            default:
            begin
                n.tx_st = ST_IDLE;
            end
        endcase

        // Receiver
        case (r.rx_st)
            ST_IDLE:
            begin
                n.rx_sub = 4'h0;
                n.rx_bit = 4'h0;
                // Mode 0 waits for the flag to clear, so it cannot spin
                if (ren && m0 && !r.serial_control[SC_RX_DONE] && r.tx_st == ST_IDLE)
                    n.rx_st = ST_DATA;
                else if (ren && !m0 && rxd_fall)
                    n.rx_st = ST_START;
            end
            ST_START:
            begin
                if (rx_tick)
                begin
                    if (r.rx_sub == SUB_MID)
                    begin
                        n.rx_sub = 4'h0;
                        // A glitch shorter than half a bit is dropped
                        n.rx_st  = rxd_lvl ? ST_IDLE : ST_DATA;
                    end
                    else
                    begin
                        n.rx_sub = r.rx_sub + 4'h1;
                    end
                end
            end
            ST_DATA:
            begin
                if (rx_tick)
                begin
                    if (m0 && r.rx_sub == M0_SAMPLE)
                        n.rx_sh = smp;
                    if (r.rx_sub == sub_last)
                    begin
                        n.rx_sub = 4'h0;
                        n.rx_bit = r.rx_bit + 4'h1;
                        if (!m0 && r.rx_bit <= RX_LAST_M8)
                            n.rx_sh = smp;
                    end
                    else
                    begin
                        n.rx_sub = r.rx_sub + 4'h1;
                    end
                end
                if (rx_done)
                begin
                    n.rx_st = ST_IDLE;
                    if (m0)
                    begin
                        n.rbuf = n.rx_sh[8:1];
                        n.serial_control[SC_RX_DONE] = 1'b1;
                    end
                    else if (!r.serial_control[SC_RX_DONE] && (!r.serial_control[SC_MPF] || n.rx_sh[8]))
                    begin
                        n.rbuf = n.rx_sh[7:0];
                        n.serial_control[SC_RX_NINTH] = n.rx_sh[8];
                        n.serial_control[SC_RX_DONE] = 1'b1;
                    end
                end
            end
            default:
            begin
                n.rx_st = ST_IDLE;
            end
        endcase
        if (!ren)
            n.rx_st = ST_IDLE;

        // Pins follow the next state so they leave a flop
        n.rxd_oe  = m0 & (n.tx_st != ST_IDLE);
        n.rxd_out = n.tx_sh[0] | ~n.rxd_oe;
        if (m0)
            n.txd = ~(((n.tx_st != ST_IDLE) && n.tx_sub < M0_CLK_HIGH)
                   || ((n.rx_st != ST_IDLE) && n.rx_sub < M0_CLK_HIGH));
        else
            n.txd = (n.tx_st == ST_IDLE) | n.tx_sh[0];
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            r <= '0;
            r.serial_control    <= RST_SERIAL_CONTROL;
            r.power_control    <= RST_POWER_CONTROL;
            r.t2c     <= RST_TMR2_CONTROL;
            r.rl      <= RST_RELOAD;
            r.rh      <= RST_RELOAD;
            r.t1rh    <= RST_RELOAD;
            r.txd     <= 1'b1;
            r.rxd_out <= 1'b1;
            r.rxd_s   <= 3'h7;
            r.eclk_s  <= 3'h0;
            r.trig_s  <= 3'h0;
        end
        else
        begin
            r <= n;
        end
    end

    assign pready  = r.pready;
    assign prdata  = r.prdata;
    assign pslverr = r.pslverr;
    assign txd     = r.txd;
    assign rxd_out = r.rxd_out;
    assign rxd_oe  = r.rxd_oe;

    ////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    property p_ovf_block;
        (baud && !wr_t2c) |=> !$rose(r.t2c[TMR2_OVF]);
    endproperty
    a_ovf_block: assert property (p_ovf_block) else $error("overflow flag set in baud mode");

    property p_trig_block;
        (baud && !wr_t2c) |=> !$rose(r.t2c[TMR2_EXT_FLAG]);
    endproperty
    a_trig_block: assert property (p_trig_block) else $error("trigger acted in baud mode");

    property p_mpf;
        ($rose(r.serial_control[SC_RX_DONE]) && m9 && r.serial_control[SC_MPF] && !$past(wr_serial_control)) |-> r.serial_control[SC_RX_NINTH];
    endproperty
    a_mpf: assert property (p_mpf) else $error("frame with ninth bit 0 accepted");

    property p_tx_done;
        ($rose(r.serial_control[SC_TX_DONE]) && !m0 && !$past(wr_serial_control)) |-> r.txd;
    endproperty
    a_tx_done: assert property (p_tx_done) else $error("transmit flag not at stop bit");

    property p_m0_clock;
        (m0 && r.tx_st == ST_DATA && r.tx_sub == 4'h0) |-> !r.txd [*6] ##1 r.txd [*6];
    endproperty
    a_m0_clock: assert property (p_m0_clock) else $error("mode 0 clock not osc/12");

    property p_m2_fast;
        (m2_fast && $past(m2_fast) && $past(m2_fast, 2) && $past(rx_tick, 2))
            |-> (!$past(rx_tick) && rx_tick);
    endproperty
    a_m2_fast: assert property (p_m2_fast) else $error("mode 2 doubled rate wrong");

    property p_m2_slow;
        (m2_slow && $past(m2_slow) && $past(m2_slow, 2) && $past(m2_slow, 3) && $past(m2_slow, 4)
            && $past(rx_tick, 4)) |-> (!$past(rx_tick, 3) && !$past(rx_tick, 2) && !$past(rx_tick) && rx_tick);
    endproperty
    a_m2_slow: assert property (p_m2_slow) else $error("mode 2 rate wrong");

    property p_tmr1_gap;
        tmr1_ovf |=> !tmr1_ovf [*8];
    endproperty
    a_tmr1_gap: assert property (p_tmr1_gap) else $error("timer 1 overflows too fast");

    property p_ren;
        !ren |=> (r.rx_st == ST_IDLE);
    endproperty
    a_ren: assert property (p_ren) else $error("receiver busy while disabled");

    property p_tmr2_half;
        (baud && run && !extclk && tmr2_inc) |=> !tmr2_inc;
    endproperty
    a_tmr2_half: assert property (p_tmr2_half) else $error("timer 2 baud count not osc/2");

endmodule : sprt_top

//--- tb/sprt_peer.sv
`timescale 1ns/1ps

module sprt_peer (
    // Clock
    input  wire logic clk,
    // Line
    input  wire logic txd,
    output logic      rxd
);
    initial rxd = 1'b1;

    // Start bit first, then LSB first; idle mark after the stop bit
    task send(input logic [10:0] f, input int per);
        for (int i = 0; i < 11; i++)
        begin
            rxd <= f[i];
            repeat (per) @(posedge clk);
        end
        rxd <= 1'b1;
    endtask : send

    // Samples mid bit, so jitter of a cycle or two is tolerated
    task grab(output logic [10:0] f, input int per);
        while (txd !== 1'b0) @(posedge clk);
        repeat (per / 2) @(posedge clk);
        for (int i = 0; i < 11; i++)
        begin
            f[i] = txd;
            repeat (per) @(posedge clk);
        end
    endtask : grab
endmodule : sprt_peer

//--- tb/tb_serial_port_baud_generation.sv
`timescale 1ns/1ps

module tb_serial_port_baud_generation;
    import sprt_pkg::*;
    logic                clk, resetn, psel, penable, pwrite, pready, pslverr;
    logic                rxd_in, rxd_out, rxd_oe, txd, t2_pin;
    logic [ADDR_W-1:0]   paddr;
    logic [31:0]         pwdata, prdata, v;
    logic                e;
    logic [10:0]         fr;
    int                  fails, n_compared, cyc;

    sprt_top i_dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd(txd),
        .timer2_clock_pin(t2_pin), .timer2_ext_trigger(t2_pin));
    sprt_peer i_peer (.clk(clk), .txd(txd), .rxd(rxd_in));

    ////////////////////////////////////////////////////////////////
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        v = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task test_done;
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : test_done

    ////////////////////////////////////////////////////////////////
    task t_regs;
        apb(0, IDX_SERIAL_CONTROL, 8'h00);
        chk("serial_control", v, 32'h0);
        apb(1, 8'h00, 8'h5a);
        chk("unmapped err", 32'(e), 32'h1);
        apb(1, IDX_POWER_CONTROL, 8'h80);
        apb(0, IDX_POWER_CONTROL, 8'h00);
        chk("power_control", v, 32'h80);
        apb(1, IDX_TMR1_RELOAD_HI, 8'hff);
        apb(0, IDX_TMR1_RELOAD_HI, 8'h00);
        chk("timer1_reload_high", v, 32'hff);
        $display("test regs done");
    endtask : t_regs

    // Mode 2, doubled: 32 oscillator cycles a bit
    task t_tx;
        apb(1, IDX_SERIAL_CONTROL, 8'h88);
        apb(1, IDX_SERIAL_DATA, 8'ha5);
        i_peer.grab(fr, 32);
        chk("tx frame", 32'(fr), 32'h3 << 9 | 32'ha5 << 1);
        apb(0, IDX_SERIAL_CONTROL, 8'h00);
        chk("tx done", v & 32'h2, 32'h2);
        $display("test tx done");
    endtask : t_tx

    task t_rx;
        apb(1, IDX_SERIAL_CONTROL, 8'hb0);
        i_peer.send({2'b10, 8'h3c, 1'b0}, 32);
        apb(0, IDX_SERIAL_CONTROL, 8'h00);
        chk("filtered done", v & 32'h1, 32'h0);
        // Undoubled mode 2: 64 oscillator cycles a bit
        apb(1, IDX_POWER_CONTROL, 8'h00);
        i_peer.send({2'b11, 8'h3c, 1'b0}, 64);
        apb(0, IDX_SERIAL_CONTROL, 8'h00);
        chk("rx status", v, 32'hb5);
        apb(0, IDX_SERIAL_DATA, 8'h00);
        chk("rx data", v, 32'h3c);
        apb(1, IDX_POWER_CONTROL, 8'h80);
        $display("test rx done");
    endtask : t_rx

    task t2_fall;
        t2_pin <= 1'b0;
        repeat (4) @(posedge clk);
        t2_pin <= 1'b1;
        @(posedge clk);
    endtask : t2_fall

    // Short reload so timer 2 overflows every 32 cycles in baud mode, every 192 otherwise
    task t_t2;
        logic [7:0] codes [3] = '{8'h34, 8'h24, 8'h14};
        apb(1, IDX_TMR2_RELOAD_HI, 8'hff);
        apb(1, IDX_TMR2_RELOAD_LO, 8'hf0);
        // Counter leaves reset at zero; a trigger in reload mode loads the short value
        apb(1, IDX_TMR2_CONTROL, 8'h0c);
        t2_fall();
        repeat (300) @(posedge clk);
        apb(0, IDX_TMR2_CONTROL, 8'h00);
        chk("t2 reload flags", v, 32'hcc);
        apb(1, IDX_TMR2_CONTROL, 8'h00);
        foreach (codes[i])
        begin
            apb(1, IDX_TMR2_CONTROL, codes[i]);
            repeat (200) @(posedge clk);
            apb(0, IDX_TMR2_CONTROL, 8'h00);
            chk("t2 ovf flag", v, 32'(codes[i]));
        end
        // Trigger enabled in baud mode must be ignored
        apb(1, IDX_TMR2_CONTROL, 8'h3c);
        t2_fall();
        repeat (20) @(posedge clk);
        apb(0, IDX_TMR2_CONTROL, 8'h00);
        chk("t2 baud trigger", v, 32'h3c);
        apb(1, IDX_TMR2_CONTROL, 8'h00);
        $display("test timer2 done");
    endtask : t_t2

    // Mode 0: data leaves on the data pin, taken at each rising shift clock
    task t_m0;
        apb(1, IDX_SERIAL_CONTROL, 8'h00);
        apb(1, IDX_SERIAL_DATA, 8'h96);
        for (int i = 0; i < 8; i++)
        begin
            while (txd !== 1'b0) @(posedge clk);
            while (txd !== 1'b1) @(posedge clk);
            fr[i] = rxd_out;
            chk("m0 drive", 32'(rxd_oe), 32'h1);
        end
        chk("m0 data", 32'(fr[7:0]), 32'h96);
        repeat (12) @(posedge clk);
        apb(0, IDX_SERIAL_CONTROL, 8'h00);
        chk("m0 tx done", v, 32'h2);
        $display("test mode0 done");
    endtask : t_m0

    // Mode 1 from timer 1, reload ff and doubled: 192 oscillator cycles a bit
    task t_m1;
        // Timer 1 leaves reset at zero; the short reload applies only from its first wrap on
        while (cyc < 3300) @(posedge clk);
        apb(1, IDX_SERIAL_CONTROL, 8'h40);
        apb(1, IDX_SERIAL_DATA, 8'h5c);
        i_peer.grab(fr, 192);
        chk("m1 frame", 32'(fr), 32'h3 << 9 | 32'h5c << 1);
        apb(1, IDX_SERIAL_CONTROL, 8'h50);
        i_peer.send({2'b11, 8'h81, 1'b0}, 192);
        apb(0, IDX_SERIAL_CONTROL, 8'h00);
        chk("m1 rx status", v, 32'h55);
        apb(0, IDX_SERIAL_DATA, 8'h00);
        chk("m1 rx data", v, 32'h81);
        $display("test mode1 done");
    endtask : t_m1

    ////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fails++;
            test_done();
        end
    end

    initial
    begin
        resetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        t2_pin = 1'b1;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        t_regs();
        t_tx();
        t_rx();
        t_t2();
        t_m0();
        t_m1();
        test_done();
    end
endmodule : tb_serial_port_baud_generation
